// File: mid_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mid_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] pm_addr,
    input wire logic [12:0] pm_data,
    input wire logic        osc_stop,
    input wire logic        irq_en,
    input wire logic [7:0]  control_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire acc_ph = psel && penable;
    wire hole   = (paddr >= 8'h18) && (paddr < 8'h40);
    ////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_phase: assert property (pslverr |-> acc_ph)
        else $error("pslverr outside access phase");
    a_err_hole: assert property (acc_ph && hole |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc_ph && paddr < 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_ctrl_cause: assert property (
        !$stable(control_register) |-> $past(pm_data) == 13'h0002)
        else $error("control register changed without its write word");
    a_irq_rise: assert property (
        $rose(irq_en) |-> $past(pm_data) inside {13'h0010, 13'h0013})
        else $error("interrupts enabled without cause");
    a_irq_fall: assert property ($fell(irq_en) |-> $past(pm_data) == 13'h0011)
        else $error("interrupts disabled without cause");
    a_sleep_cause: assert property ($rose(osc_stop) |-> $past(pm_data) == 13'h0003)
        else $error("oscillator stopped without sleep word");
    a_sleep_pc: assert property (osc_stop && $past(osc_stop) |-> $stable(pm_addr))
        else $error("program address moved in sleep");
    c_sleep: cover property ($rose(osc_stop));
    c_irq_on: cover property ($rose(irq_en));
    c_refused: cover property (acc_ph && pslverr);
endmodule

bind mid_decoder mid_asserts u_chk (.ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .pm_addr, .pm_data, .osc_stop, .irq_en,
    .control_register);
`default_nettype wire

// File: mid_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "mid_regs.vh"

// Operation
// RQ1: bank bits 6,7 select direct operand bank
// RQ2: 8-bit literals, 10-bit call/jump targets
// RQ3: sleep clears watchdog, stops oscillator, sets T,P; code sets T but clears P
// RQ4: watchdog clear zeroes counter, sets T,P
// RQ5: 0002/0014 move accumulator and control register
// RQ6: io control move only for 5-7,B,E,F
// RQ7: 0010 enables, 0011 disables interrupts
// RQ8: return pops pc; irq return also enables
// RQ9: table adds A to pc low, Z,C,DC
// RQ10: decimal adjust accumulator, carry only
// RQ11: store A to register; clear sets Z
// RQ12: subtract is operand minus A; Z,C,DC
// RQ13: logic, move, inc, dec update Z only
// RQ14: inc/dec skip on zero, no flags
// RQ15: rotates go through carry, carry only
// RQ16: nibble swap without flag change
// RQ17: bit clear, set, skip-if-clear, skip-if-set
// RQ18: bit set never touches register 3F
// RQ19: call pushes pc+1, loads page and literal
// RQ20: jump loads page and literal, no stack
// RQ21: return with literal loads A, pops pc
// RQ22: software interrupt pushes pc+1, jumps 002
// RQ23: pc change or taken skip costs two cycles
// RQ24: unknown words act as no-operation
// RQ25: five-deep stack, overflow overwrites oldest
module mid_decoder #(
    parameter WDT_CYCLES = `MID_WDT_CYCLES
) (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [11:0] pm_addr,
    input  wire [12:0] pm_data,
    output wire        osc_stop,
    output reg         irq_en,
    output reg  [7:0]  control_register
);

localparam ST_FETCH = 3'd0;
localparam ST_EXEC  = 3'd1;
localparam ST_FL0   = 3'd2;
localparam ST_FL1   = 3'd3;
localparam ST_SLEEP = 3'd4;
localparam integer SP_LAST_I = `MID_STACK_DEPTH - 1;
localparam [2:0]   SP_LAST   = SP_LAST_I[2:0];

////////////////////////////////////////////////////////////////////////////////
// helpers

function [9:0] add9;
    input [7:0] x;
    input [7:0] y;
    input       ci;
    reg   [8:0] s;
    reg   [4:0] n;
    begin
        s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        add9 = {n[4], s[8], s[7:0]};
    end
endfunction

function ioc_ok;
    input [3:0] r;
    begin
        ioc_ok = (r >= 4'h5 && r <= 4'h7) || r == 4'hb || r == 4'he || r == 4'hf;
    end
endfunction

function [2:0] sp_step;
    input [2:0] p;
    input       up;
    begin
        if (up)
            sp_step = (p == SP_LAST) ? 3'd0 : p + 3'd1;
        else
            sp_step = (p == 3'd0) ? SP_LAST : p - 3'd1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// state

reg  [2:0]  state_r;
reg  [11:0] pc_r;
reg  [7:0]  acc_r;
reg  [7:0]  stat_r;
reg  [7:0]  bsr_r;
reg  [7:0]  gpr_r [0:255];
reg  [7:0]  ioc_r [0:15];
reg  [11:0] stk_r [0:`MID_STACK_DEPTH-1];
reg  [2:0]  sp_r;
reg  [31:0] wdt_r;
reg         run_r;

wire        apb_acc = psel & penable;
wire        apb_wr  = apb_acc & pwrite;
wire        ioc_hit = paddr >= `MID_OFS_IOC && paddr <= `MID_OFS_IOC_END && paddr[1:0] == 2'b00;
wire        mapped  = ioc_hit || paddr == `MID_OFS_CTRL || paddr == `MID_OFS_STAT ||
                      paddr == `MID_OFS_ACC || paddr == `MID_OFS_PC ||
                      paddr == `MID_OFS_CONTROL_REGISTER || paddr == `MID_OFS_WDT;
wire        wake    = (apb_wr && paddr == `MID_OFS_CTRL && pwdata[`MID_CTRL_WAKE]);
wire        wdt_to  = (wdt_r >= WDT_CYCLES - 1);
wire [12:0] ir      = pm_data;
wire [5:0]  ra      = ir[5:0];
wire [2:0]  bidx    = ir[8:6];
wire [7:0]  lit     = ir[7:0];                                   // [RQ2]
wire [7:0]  gidx    = (ra < `MID_R_BANKED) ? {2'b00, ra}
                                           : {bsr_r[`MID_BSR_HI:`MID_BSR_LO], ra}; // [RQ1]
wire [7:0]  rv      = (ra == `MID_R_PCL)  ? pc_r[7:0] :
                      (ra == `MID_R_STAT) ? stat_r :
                      (ra == `MID_R_BSR)  ? bsr_r : gpr_r[gidx];

assign pready   = 1'b1;
assign pslverr  = apb_acc & ~mapped;
assign osc_stop = (state_r == ST_SLEEP);

////////////////////////////////////////////////////////////////////////////////
// execute

reg         wr_en;
reg  [7:0]  wr_d;
reg  [7:0]  a_nxt;
reg  [7:0]  res;
reg  [9:0]  sum;
reg  [7:0]  st_nxt;
reg  [11:0] pc_nxt;
reg         chg;
reg         push;
reg         pop;
reg         go_sleep;
reg         wdt_clr;
reg         control_register_wr;
reg         ioc_wr;
reg         ie_set;
reg         ie_clr;
reg  [7:0]  dv;

always @* begin
    wr_en    = 1'b0;
    wr_d     = 8'h00;
    a_nxt    = acc_r;
    res      = 8'h00;
    sum      = 10'h000;
    st_nxt   = stat_r;
    pc_nxt   = pc_r;
    chg      = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    go_sleep = 1'b0;
    wdt_clr  = 1'b0;
    control_register_wr  = 1'b0;
    ioc_wr   = 1'b0;
    ie_set   = 1'b0;
    ie_clr   = 1'b0;
    dv       = 8'h00;
    casez (ir)
        13'b0_0000_0000_0000: ;
        13'b0_0000_0000_0001: begin                               // [RQ10]
            dv = 8'h00;
            if (acc_r[3:0] > 4'h9 || stat_r[`MID_ST_DC])
                dv[3:0] = 4'h6;
            if (acc_r > 8'h99 || stat_r[`MID_ST_C]) begin
                dv[7:4] = 4'h6;
                st_nxt[`MID_ST_C] = 1'b1;
            end
            a_nxt = acc_r + dv;
        end
        13'b0_0000_0000_0010: control_register_wr = 1'b1;                     // [RQ5]
        13'b0_0000_0000_0011: begin                               // [RQ3]
            wdt_clr  = 1'b1;
            go_sleep = 1'b1;
            st_nxt[`MID_ST_T] = 1'b1;
            st_nxt[`MID_ST_P] = 1'b0;
        end
        13'b0_0000_0000_0100: begin                               // [RQ4]
            wdt_clr = 1'b1;
            st_nxt[`MID_ST_T] = 1'b1;
            st_nxt[`MID_ST_P] = 1'b1;
        end
        13'b0_0000_0000_????: ioc_wr = ioc_ok(ir[3:0]);           // [RQ6]
        13'b0_0000_0001_0000: ie_set = 1'b1;                      // [RQ7]
        13'b0_0000_0001_0001: ie_clr = 1'b1;                      // [RQ7]
        13'b0_0000_0001_0010: pop = 1'b1;                         // [RQ8]
        13'b0_0000_0001_0011: begin                               // [RQ8]
            pop    = 1'b1;
            ie_set = 1'b1;
        end
        13'b0_0000_0001_0100: a_nxt = control_register;           // [RQ5]
        13'b0_0000_0001_????: begin                               // [RQ6]
            if (ioc_ok(ir[3:0]))
                a_nxt = ioc_r[ir[3:0]];
        end
        13'b0_0000_0010_0000: begin                               // [RQ9]
            sum    = add9(pc_r[7:0], acc_r, 1'b0);
            pc_nxt = {pc_r[11:8], sum[7:0]};
            chg    = 1'b1;
            st_nxt[`MID_ST_Z]  = (sum[7:0] == 8'h00);
            st_nxt[`MID_ST_C]  = sum[8];
            st_nxt[`MID_ST_DC] = sum[9];
        end
        13'b0_0000_01??_????: begin                               // [RQ11]
            wr_en = 1'b1;
            wr_d  = acc_r;
        end
        13'b0_0000_1000_0000: begin
            a_nxt = 8'h00;
            st_nxt[`MID_ST_Z] = 1'b1;
        end
        13'b0_0000_11??_????: begin                               // [RQ11]
            wr_en = 1'b1;
            wr_d  = 8'h00;
            st_nxt[`MID_ST_Z] = 1'b1;
        end
        13'b0_0000_????_????: ;                                   // [RQ24]
        13'b0_0???_????_????: begin
            case (ir[11:7])
                5'b0001_0, 5'b0011_1: begin                       // [RQ12]
                    sum = ir[9] ? add9(acc_r, rv, 1'b0) : add9(rv, ~acc_r, 1'b1);
                    res = sum[7:0];
                    st_nxt[`MID_ST_C]  = sum[8];
                    st_nxt[`MID_ST_DC] = sum[9];
                    st_nxt[`MID_ST_Z]  = (res == 8'h00);
                end
                5'b0001_1: res = rv - 8'h01;
                5'b0010_0: res = acc_r | rv;
                5'b0010_1: res = acc_r & rv;
                5'b0011_0: res = acc_r ^ rv;
                5'b0100_0: res = rv;
                5'b0100_1: res = ~rv;
                5'b0101_0: res = rv + 8'h01;
                5'b0101_1, 5'b0111_1: begin                       // [RQ14]
                    res = ir[9] ? rv + 8'h01 : rv - 8'h01;
                    if (res == 8'h00) begin
                        pc_nxt = pc_r + 12'h001;
                        chg    = 1'b1;
                    end
                end
                5'b0110_0: begin                                  // [RQ15]
                    res = {stat_r[`MID_ST_C], rv[7:1]};
                    st_nxt[`MID_ST_C] = rv[0];
                end
                5'b0110_1: begin                                  // [RQ15]
                    res = {rv[6:0], stat_r[`MID_ST_C]};
                    st_nxt[`MID_ST_C] = rv[7];
                end
                5'b0111_0: res = {rv[3:0], rv[7:4]};              // [RQ16]
                default: res = rv;
            endcase
            if (ir[11:7] != 5'b0001_0 && ir[11:7] != 5'b0011_1 &&
                ir[11:9] != 3'b011 && ir[11:7] != 5'b0101_1 && ir[11:7] != 5'b0111_1)
                st_nxt[`MID_ST_Z] = (res == 8'h00);               // [RQ13]
            if (ir[6]) begin                                      // [RQ13]
                wr_en = 1'b1;
                wr_d  = res;
            end else begin
                a_nxt = res;
            end
        end
        13'b0_1???_????_????: begin                               // [RQ17]
            case (ir[10:9])
                2'b00: begin
                    wr_en = 1'b1;
                    wr_d  = rv & ~(8'h01 << bidx);
                end
                2'b01: begin
                    wr_en = (ra != `MID_R_3F);                    // [RQ18]
                    wr_d  = rv | (8'h01 << bidx);
                end
                default: begin
                    if (rv[bidx] == ir[9]) begin                  // [RQ23]
                        pc_nxt = pc_r + 12'h001;
                        chg    = 1'b1;
                    end
                end
            endcase
        end
        13'b1_0???_????_????: begin                               // [RQ19] [RQ20]
            pc_nxt = {stat_r[`MID_ST_PAGE_HI:`MID_ST_PAGE_LO], ir[9:0]};
            push   = ~ir[10];
            chg    = 1'b1;
        end
        13'b1_1000_????_????: a_nxt = lit;
        13'b1_1001_????_????: begin
            a_nxt = acc_r | lit;
            st_nxt[`MID_ST_Z] = (a_nxt == 8'h00);
        end
        13'b1_1010_????_????: begin
            a_nxt = acc_r & lit;
            st_nxt[`MID_ST_Z] = (a_nxt == 8'h00);
        end
        13'b1_1011_????_????: begin
            a_nxt = acc_r ^ lit;
            st_nxt[`MID_ST_Z] = (a_nxt == 8'h00);
        end
        13'b1_1100_????_????: begin                               // [RQ21]
            a_nxt = lit;
            pop   = 1'b1;
        end
        13'b1_1101_????_????, 13'b1_1111_????_????: begin         // [RQ12]
            sum   = ir[9] ? add9(acc_r, lit, 1'b0) : add9(lit, ~acc_r, 1'b1);
            a_nxt = sum[7:0];
            st_nxt[`MID_ST_C]  = sum[8];
            st_nxt[`MID_ST_DC] = sum[9];
            st_nxt[`MID_ST_Z]  = (sum[7:0] == 8'h00);
        end
        13'b1_1110_0000_0010: begin                               // [RQ22]
            push   = 1'b1;
            pc_nxt = `MID_INT_VECTOR;
            chg    = 1'b1;
        end
        default: ;                                                // [RQ24]
    endcase
    // explicit writes to pc low, or to status bits 7:5, land after flag updates; status bits 4:0 keep the flag values
    if (wr_en && ra == `MID_R_PCL) begin
        pc_nxt = {pc_r[11:8], wr_d};
        chg    = 1'b1;                                            // [RQ23]
    end
    if (wr_en && ra == `MID_R_STAT)
        st_nxt = (wr_d & 8'he0) | (st_nxt & 8'h1f);
    if (pop) begin
        pc_nxt = stk_r[sp_step(sp_r, 1'b0)];                      // [RQ8]
        chg    = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencing

wire exec = (state_r == ST_EXEC);

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        state_r <= ST_FETCH;
        pc_r    <= 12'h000;
        pm_addr <= 12'h000;
        acc_r   <= 8'h00;
        stat_r  <= `MID_STAT_RST;
        bsr_r   <= 8'h00;
        sp_r    <= 3'd0;
        irq_en  <= 1'b0;
        control_register <= `MID_CONTROL_REGISTER_RST;
    end else begin
        case (state_r)
            ST_FETCH: begin
                if (run_r) begin
                    pc_r    <= pc_r + 12'h001;
                    state_r <= ST_EXEC;
                end
            end
            ST_EXEC: begin
                pc_r    <= pc_nxt;
                pm_addr <= pc_nxt;
                acc_r   <= a_nxt;
                stat_r  <= st_nxt;
                if (wr_en && ra == `MID_R_BSR)
                    bsr_r <= wr_d;
                if (push) begin                                   // [RQ25]
                    sp_r <= sp_step(sp_r, 1'b1);
                end else if (pop) begin
                    sp_r <= sp_step(sp_r, 1'b0);
                end
                if (ie_set)
                    irq_en <= 1'b1;
                else if (ie_clr)
                    irq_en <= 1'b0;
                if (control_register_wr)
                    control_register <= acc_r;
                state_r <= chg ? ST_FL0 : (go_sleep ? ST_SLEEP : ST_FETCH); // [RQ23]
            end
            ST_FL0:   state_r <= ST_FL1;
            ST_FL1:   state_r <= ST_FETCH;
            ST_SLEEP: begin
                if (wake || wdt_to)
                    state_r <= ST_FETCH;
            end
            default:  state_r <= ST_FETCH;
        endcase
        // a timeout clears T in any core state and beats a same-cycle set
        if (wdt_to)
            stat_r[`MID_ST_T] <= 1'b0;
    end
end

// storage arrays carry no reset; software initialises them
genvar gi;
generate
    for (gi = 0; gi < `MID_STACK_DEPTH; gi = gi + 1) begin : g_stk
        always @(posedge ref_clk) begin
            if (exec && push && sp_r == gi)
                stk_r[gi] <= pc_r;                                // [RQ19]
        end
    end
endgenerate

always @(posedge ref_clk) begin
    if (exec && wr_en && ra != `MID_R_PCL && ra != `MID_R_STAT && ra != `MID_R_BSR)
        gpr_r[gidx] <= wr_d;
    if (exec && ioc_wr)
        ioc_r[ir[3:0]] <= acc_r;                                  // [RQ6]
end

// watchdog keeps counting in sleep; the core oscillator alone stops
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
        wdt_r <= 32'h0000_0000;
    else if ((exec && wdt_clr) || wdt_to)
        wdt_r <= 32'h0000_0000;                                   // [RQ3] [RQ4]
    else
        wdt_r <= wdt_r + 32'h0000_0001;
end

////////////////////////////////////////////////////////////////////////////////
// apb slave

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        run_r  <= `MID_CTRL_RST;
        prdata <= 32'h0000_0000;
    end else begin
        if (apb_wr && paddr == `MID_OFS_CTRL)
            run_r <= pwdata[`MID_CTRL_RUN];
        if (psel && !penable) begin
            if (ioc_hit)
                prdata <= {24'h000000, ioc_r[paddr[5:2]]};
            else begin
                case (paddr)
                    `MID_OFS_CTRL: prdata <= {31'h0, run_r};
                    `MID_OFS_STAT: prdata <= {16'h0000, 5'h00, state_r, stat_r};
                    `MID_OFS_ACC:  prdata <= {24'h000000, acc_r};
                    `MID_OFS_PC:   prdata <= {17'h00000, sp_r, pc_r};
                    `MID_OFS_CONTROL_REGISTER: prdata <= {23'h000000, irq_en, control_register};
                    `MID_OFS_WDT:  prdata <= wdt_r;
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
end

endmodule
`default_nettype wire

// File: mid_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mid_prog_mem (
    input  wire logic        ref_clk,
    input  wire logic [11:0] pm_addr,
    output var  logic [12:0] pm_data,
    input  wire logic        ld_en,
    input  wire logic [11:0] ld_addr,
    input  wire logic [12:0] ld_data
);
    logic [12:0] rom [0:4095];
    initial begin
        foreach (rom[i]) rom[i] = 13'h0;
    end
    // synchronous read: the word for an address appears one clock later
    always @(posedge ref_clk) begin
        if (ld_en) begin
            rom[ld_addr] <= ld_data;
        end
        pm_data <= rom[pm_addr];
    end
endmodule
`default_nettype wire

// File: mid_regs.vh
`ifndef MID_REGS_VH
`define MID_REGS_VH

// apb register offsets (byte addresses)
`define MID_OFS_CTRL     8'h00
`define MID_OFS_STAT     8'h04
`define MID_OFS_ACC      8'h08
`define MID_OFS_PC       8'h0c
`define MID_OFS_CONTROL_REGISTER     8'h10
`define MID_OFS_WDT      8'h14
`define MID_OFS_IOC      8'h40
`define MID_OFS_IOC_END  8'h7c

// ctrl register fields
`define MID_CTRL_RUN     0
`define MID_CTRL_WAKE    1
`define MID_CTRL_RST     1'b0

// status register fields
`define MID_ST_C         0
`define MID_ST_DC        1
`define MID_ST_Z         2
`define MID_ST_P         3
`define MID_ST_T         4
`define MID_ST_PAGE_LO   5
`define MID_ST_PAGE_HI   6
`define MID_STAT_RST     8'h18

// special register file addresses
`define MID_R_PCL        6'h02
`define MID_R_STAT       6'h03
`define MID_R_BSR        6'h04
`define MID_R_3F         6'h3f
`define MID_R_BANKED     6'h10
`define MID_BSR_LO       6
`define MID_BSR_HI       7

`define MID_CONTROL_REGISTER_RST     8'h00
`define MID_INT_VECTOR   12'h002
`define MID_STACK_DEPTH  5

// timing
`define MID_CLK_MHZ      100
`define MID_WDT_US       16200
`define MID_WDT_CYCLES   (`MID_WDT_US * `MID_CLK_MHZ)

`endif

// File: test_mcu_instruction_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mid_regs.vh"
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module test_mcu_instruction_decoder;
    logic        ref_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [7:0]  paddr   = 8'h0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic        ld_en   = 1'b0;
    logic [11:0] ld_addr = 12'h0;
    logic [12:0] ld_data = 13'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, osc_stop, irq_en;
    wire  [11:0] pm_addr;
    wire  [12:0] pm_data;
    wire  [7:0]  ctl;
    logic [31:0] rdat;
    logic        rerr;
    int          failures = 0;
    int          checked  = 0;

    mid_decoder #(.WDT_CYCLES(400)) dut (.ref_clk, .rst_b, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .pm_addr, .pm_data, .osc_stop,
        .irq_en, .control_register(ctl));
    mid_prog_mem rom (.ref_clk, .pm_addr, .pm_data, .ld_en, .ld_addr, .ld_data);

    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rdat & m)
    endtask

    // hold the core in reset, load a program, then let it run
    task automatic run(input logic [12:0] p[$], input int cyc);
        rst_b <= 1'b0;
        foreach (p[i]) begin
            @(posedge ref_clk);
            ld_en   <= 1'b1;
            ld_addr <= 12'(i);
            ld_data <= p[i];
        end
        @(posedge ref_clk);
        ld_en <= 1'b0;
        rst_b <= 1'b1;
        apb(1'b1, `MID_OFS_CTRL, 32'h1);
        repeat (cyc) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        rc(`MID_OFS_STAT, 32'h18);
        rc(`MID_OFS_CTRL, 32'h0);
        rc(`MID_OFS_CONTROL_REGISTER, 32'h0);
        rc(8'h20, 32'h0);
        `CHK("slverr", 1'b1, rerr)
        // arithmetic flags, stashed through io control registers
        run('{13'h1815, 13'h1ff0, 13'h0403, 13'h0005, 13'h1803, 13'h1d02, 13'h0006,
              13'h0403, 13'h0007, 13'h1899, 13'h1f01, 13'h0001, 13'h000b, 13'h0403,
              13'h000e, 13'h140f}, 200);
        rc(8'h54, 32'h19);
        rc(8'h58, 32'hff);
        rc(8'h5c, 32'h18);
        rc(8'h6c, 32'h00);
        rc(8'h78, 32'h19);
        apb(1'b1, `MID_OFS_ACC, 32'haa);
        rc(`MID_OFS_ACC, 32'h19);
        // register moves, swap, rotates, bit ops and skips
        run('{13'h18a5, 13'h0048, 13'h0708, 13'h0005, 13'h0688, 13'h0006, 13'h0608,
              13'h0007, 13'h0a48, 13'h0408, 13'h000b, 13'h0e08, 13'h1800, 13'h0c08,
              13'h1811, 13'h000e, 13'h18ff, 13'h0049, 13'h07c9, 13'h1822, 13'h000f,
              13'h1415}, 200);
        rc(8'h54, 32'h5a);
        rc(8'h58, 32'h4a);
        rc(8'h5c, 32'hd2);
        rc(8'h6c, 32'ha7);
        rc(8'h78, 32'h11);
        rc(8'h7c, 32'hff);
        // call, literal return, software interrupt, table offset, control word
        run('{13'h1404, 13'h0000, 13'h0013, 13'h0000, 13'h0011, 13'h1013, 13'h0005,
              13'h1e02, 13'h1855, 13'h0002, 13'h1801, 13'h0020, 13'h1866, 13'h0006,
              13'h00ff, 13'h0a3f, 13'h043f, 13'h0007, 13'h1412, 13'h1c3c}, 200);
        rc(8'h54, 32'h3c);
        rc(8'h58, 32'h01);
        rc(8'h5c, 32'h00);
        `CHK("ctl", 8'h55, ctl)
        `CHK("irq_en", 1'b1, irq_en)
        rc(`MID_OFS_CONTROL_REGISTER, 32'h155);
        // banked register access, unlisted words and a logic op
        run('{13'h18c0, 13'h0044, 13'h1877, 13'h0050, 13'h1800, 13'h0044, 13'h1811,
              13'h0050, 13'h18c0, 13'h0044, 13'h0410, 13'h0005, 13'h1e00, 13'h0030,
              13'h0006, 13'h1a0f, 13'h0007, 13'h1411}, 100);
        rc(8'h54, 32'h77);
        rc(8'h58, 32'h77);
        rc(8'h5c, 32'h07);
        // sleep, wake, watchdog clear and watchdog expiry
        run('{13'h0003, 13'h0004, 13'h1402}, 40);
        `CHK("osc_stop", 1'b1, osc_stop)
        rc(`MID_OFS_STAT, 32'h410, 32'h7ff);
        apb(1'b1, `MID_OFS_CTRL, 32'h3);
        repeat (8) @(posedge ref_clk);
        `CHK("osc_stop", 1'b0, osc_stop)
        rc(`MID_OFS_STAT, 32'h18, 32'hff);
        repeat (500) @(posedge ref_clk);
        rc(`MID_OFS_STAT, 32'h08, 32'hff);
        wrap_up();
    end
endmodule
`default_nettype wire
